// *** hw/svcu_top.sv ***
// Voltage command interpreter: levels, modes, ranging and operation condition.
`timescale 1ns/10ps
module svcu_top #(
    parameter int unsigned CYC_PER_MS = svcu_pkg::CYC_PER_MS,
    parameter logic [15:0] MODEL_MAX = svcu_pkg::MODEL_MAX_DEF,
    parameter logic [15:0] MODEL_MIN = svcu_pkg::MODEL_MIN_DEF,
    parameter logic [15:0] QUARTER = svcu_pkg::QUARTER_DEF
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Parsed command in
    input wire logic CMD_VALID,
    input wire logic [4:0] CMD_CODE,
    input wire logic [1:0] CMD_QUAL,
    input wire logic [15:0] CMD_ARG,
    // Query reply and error queue entry
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic ERR_VALID,
    output logic [15:0] ERR_CODE,
    // List sequencer
    output logic LIST_RUN,
    input wire logic LIST_STEP_VALID,
    input wire logic [15:0] LIST_STEP_LEVEL,
    input wire logic LIST_END,
    // Output programming
    output logic [15:0] OUT_LEVEL,
    output logic [15:0] DAC_CODE,
    output logic RANGE_QUARTER_ON,
    output logic CURR_MODE
);

    initial begin
        if (CYC_PER_MS < 1 || QUARTER == 16'h0000 || MODEL_MIN > MODEL_MAX) begin
            $error("svcu_top: unusable parameter values");
        end
    end

    localparam int unsigned DUR_W = 40;
    localparam logic [DUR_W-1:0] CYC_MS = DUR_W'(CYC_PER_MS);

    svcu_pkg::svcu_state_e state_ff;
    logic [15:0] prog_ff;
    logic [15:0] nxt_prog;
    logic [15:0] saved_ff;
    logic [15:0] trig_ff;
    logic [15:0] limit_ff;
    logic [15:0] tran_ms_ff;
    logic [DUR_W-1:0] cnt_ff;
    logic auto_ff;
    logic vq_ff;
    logic cq_ff;
    logic curr_ff;
    logic [15:0] out_ff;
    logic [15:0] dac_ff;
    logic rsp_v_ff;
    logic [15:0] rsp_d_ff;
    logic err_v_ff;
    logic [15:0] err_c_ff;

    svcu_pkg::svcu_cmd_e cmd;
    logic is_cmd;
    logic arg_over;
    logic pulse_done;
    logic range_ok;
    logic v_quarter;
    logic [15:0] opc_word;
    logic [15:0] trig_clamped;
    logic [17:0] quad_level;

    assign cmd = svcu_pkg::svcu_cmd_e'(CMD_CODE);
    assign is_cmd = CMD_VALID;
    assign arg_over = CMD_ARG > MODEL_MAX;
    assign range_ok = (CMD_ARG == svcu_pkg::RANGE_FULL) || (CMD_ARG == svcu_pkg::RANGE_QUARTER);
    assign pulse_done = (state_ff == svcu_pkg::MODE_PULSE) && (cnt_ff == '0);
    // Auto ranging picks full scale only strictly above the quarter point.
    assign v_quarter = auto_ff ? (prog_ff <= QUARTER) : vq_ff;
    // The condition limit clamp caps a trigger value at the upper limit as it is stored.
    assign trig_clamped = (CMD_ARG > limit_ff) ? limit_ff : CMD_ARG;

    // Live condition word: only the two mode bits can ever be set.
    always_comb begin
        opc_word = 16'h0000;
        opc_word[svcu_pkg::OPC_CC_BIT] = curr_ff;
        opc_word[svcu_pkg::OPC_CV_BIT] = !curr_ff;
    end

    // Mode sequencing, list tracking and transient pulse.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_ff <= svcu_pkg::MODE_FIXED;
            saved_ff <= svcu_pkg::LEVEL_RST;
            tran_ms_ff <= 16'h0000;
            cnt_ff <= '0;
        end else if (is_cmd && cmd == svcu_pkg::CMD_RESET) begin
            state_ff <= svcu_pkg::MODE_FIXED;
            cnt_ff <= '0;
        end else if (pulse_done) begin
            state_ff <= svcu_pkg::MODE_FIXED;
        end else if (state_ff == svcu_pkg::MODE_PULSE) begin
            cnt_ff <= cnt_ff - 1'b1;
        end else if (state_ff == svcu_pkg::MODE_LIST && !(is_cmd && cmd == svcu_pkg::CMD_MODE_FIX)) begin
            if (LIST_END) begin
                state_ff <= svcu_pkg::MODE_FIXED;
            end
        end else if (is_cmd) begin
            unique case (cmd)
                svcu_pkg::CMD_MODE_LIST: begin
                    state_ff <= svcu_pkg::MODE_LIST;
                    saved_ff <= prog_ff;
                end
                svcu_pkg::CMD_MODE_FIX: begin
                    state_ff <= svcu_pkg::MODE_FIXED;
                end
                svcu_pkg::CMD_MODE_TRAN: begin
                    if (CMD_ARG <= 16'(svcu_pkg::TRAN_MAX_MS)) begin
                        state_ff <= svcu_pkg::MODE_ARMED;
                        tran_ms_ff <= CMD_ARG;
                    end
                end
                svcu_pkg::CMD_VOLT_SET, svcu_pkg::CMD_TRIGGER: begin
                    if (state_ff == svcu_pkg::MODE_ARMED &&
                        !(cmd == svcu_pkg::CMD_VOLT_SET && arg_over)) begin
                        state_ff <= svcu_pkg::MODE_PULSE;
                        cnt_ff <= DUR_W'(tran_ms_ff) * CYC_MS - 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Next programmed level; a pulse leaves it alone so it is restored on expiry.
    // The output register follows this next value, so a new level shows one cycle after
    // its command instead of lagging a further cycle behind the stored level.
    always_comb begin
        nxt_prog = prog_ff;
        if (is_cmd && cmd == svcu_pkg::CMD_RESET) begin
            nxt_prog = svcu_pkg::LEVEL_RST;
        end else if (state_ff == svcu_pkg::MODE_LIST) begin
            if (is_cmd && cmd == svcu_pkg::CMD_MODE_FIX) begin
                nxt_prog = saved_ff;
            end else if (LIST_STEP_VALID) begin
                nxt_prog = LIST_STEP_LEVEL;
            end
        end else if (is_cmd && state_ff != svcu_pkg::MODE_ARMED) begin
            if (cmd == svcu_pkg::CMD_VOLT_SET && !arg_over) begin
                nxt_prog = CMD_ARG;
            end else if (cmd == svcu_pkg::CMD_TRIGGER && state_ff == svcu_pkg::MODE_FIXED) begin
                nxt_prog = trig_ff;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            prog_ff <= svcu_pkg::LEVEL_RST;
        end else begin
            prog_ff <= nxt_prog;
        end
    end

    // Output level: the pulse value while timing, the programmed level otherwise.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            out_ff <= svcu_pkg::LEVEL_RST;
        end else if (is_cmd && state_ff == svcu_pkg::MODE_ARMED && cmd == svcu_pkg::CMD_VOLT_SET
                     && !arg_over) begin
            out_ff <= CMD_ARG;
        end else if (is_cmd && state_ff == svcu_pkg::MODE_ARMED && cmd == svcu_pkg::CMD_TRIGGER) begin
            out_ff <= trig_ff;
        end else if (state_ff != svcu_pkg::MODE_PULSE || pulse_done) begin
            out_ff <= nxt_prog;
        end
    end

    // Triggered value and upper level limit.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            trig_ff <= svcu_pkg::LEVEL_RST;
            limit_ff <= MODEL_MAX;
        end else if (is_cmd && cmd == svcu_pkg::CMD_TRIG_SET && !arg_over) begin
            trig_ff <= trig_clamped;
        end else if (is_cmd && cmd == svcu_pkg::CMD_LIMIT_SET && !arg_over) begin
            limit_ff <= CMD_ARG;
        end
    end

    // Function mode and range selection.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            auto_ff <= svcu_pkg::AUTO_RANGE_RST;
            vq_ff <= 1'b0;
            cq_ff <= 1'b0;
            curr_ff <= 1'b0;
        end else if (is_cmd) begin
            unique case (cmd)
                svcu_pkg::CMD_RESET: begin
                    auto_ff <= svcu_pkg::AUTO_RANGE_RST;
                    curr_ff <= 1'b0;
                end
                svcu_pkg::CMD_AUTO_SET: begin
                    auto_ff <= (CMD_ARG != 16'h0000);
                    // Turning auto off in voltage mode keeps the range it had picked, so the output does not jump.
                    if (!curr_ff) begin
                        vq_ff <= v_quarter;
                    end
                end
                svcu_pkg::CMD_RANGE_SET: begin
                    if (range_ok) begin
                        auto_ff <= 1'b0;
                        if (curr_ff) begin
                            cq_ff <= (CMD_ARG == svcu_pkg::RANGE_QUARTER);
                        end else begin
                            vq_ff <= (CMD_ARG == svcu_pkg::RANGE_QUARTER);
                        end
                    end
                end
                svcu_pkg::CMD_FUNC_MODE: begin
                    curr_ff <= CMD_ARG[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Converter code: the voltage quarter range stretches the code span over a quarter of output.
    assign quad_level = {out_ff, 2'b00};
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dac_ff <= 16'h0000;
        end else if (v_quarter) begin
            dac_ff <= (quad_level > 18'h0ffff) ? 16'hffff : quad_level[15:0];
        end else begin
            dac_ff <= out_ff;
        end
    end

    // Query replies, one cycle after the command.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rsp_v_ff <= 1'b0;
            rsp_d_ff <= 16'h0000;
        end else begin
            rsp_v_ff <= 1'b0;
            if (is_cmd) begin
                rsp_v_ff <= 1'b1;
                unique case (cmd)
                    svcu_pkg::CMD_VOLT_QUERY: begin
                        if (CMD_QUAL == svcu_pkg::QUAL_MAX) begin
                            rsp_d_ff <= MODEL_MAX;
                        end else if (CMD_QUAL == svcu_pkg::QUAL_MIN) begin
                            rsp_d_ff <= MODEL_MIN;
                        end else begin
                            rsp_d_ff <= prog_ff;
                        end
                    end
                    svcu_pkg::CMD_MODE_QUERY: begin
                        unique case (state_ff)
                            svcu_pkg::MODE_LIST: rsp_d_ff <= 16'(svcu_pkg::REPLY_LIST);
                            svcu_pkg::MODE_ARMED: rsp_d_ff <= 16'(svcu_pkg::REPLY_TRANS);
                            default: rsp_d_ff <= 16'(svcu_pkg::REPLY_FIXED);
                        endcase
                    end
                    svcu_pkg::CMD_RANGE_QUERY: begin
                        rsp_d_ff <= ((curr_ff ? cq_ff : v_quarter) ? svcu_pkg::RANGE_QUARTER
                                     : svcu_pkg::RANGE_FULL);
                    end
                    svcu_pkg::CMD_TRIG_QUERY: begin
                        rsp_d_ff <= trig_ff;
                    end
                    svcu_pkg::CMD_OPC_QUERY: begin
                        rsp_d_ff <= opc_word;
                    end
                    default: begin
                        rsp_v_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Error queue entries: out-of-range data and refused commands.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            err_v_ff <= 1'b0;
            err_c_ff <= 16'h0000;
        end else begin
            err_v_ff <= 1'b0;
            if (is_cmd) begin
                if ((cmd == svcu_pkg::CMD_VOLT_SET || cmd == svcu_pkg::CMD_TRIG_SET
                     || cmd == svcu_pkg::CMD_LIMIT_SET) && arg_over) begin
                    err_v_ff <= 1'b1;
                    err_c_ff <= svcu_pkg::ERR_RANGE;
                end else if (cmd == svcu_pkg::CMD_MODE_TRAN
                             && CMD_ARG > 16'(svcu_pkg::TRAN_MAX_MS)) begin
                    err_v_ff <= 1'b1;
                    err_c_ff <= svcu_pkg::ERR_RANGE;
                end else if (cmd == svcu_pkg::CMD_LIST_DEF && state_ff == svcu_pkg::MODE_LIST) begin
                    err_v_ff <= 1'b1;
                    err_c_ff <= svcu_pkg::ERR_COMMAND;
                end else if (cmd == svcu_pkg::CMD_RANGE_SET && !range_ok) begin
                    err_v_ff <= 1'b1;
                    err_c_ff <= svcu_pkg::ERR_RANGE;
                end
            end
        end
    end

    assign RSP_VALID = rsp_v_ff;
    assign RSP_DATA = rsp_d_ff;
    assign ERR_VALID = err_v_ff;
    assign ERR_CODE = err_c_ff;
    assign LIST_RUN = (state_ff == svcu_pkg::MODE_LIST);
    assign OUT_LEVEL = out_ff;
    assign DAC_CODE = dac_ff;
    assign RANGE_QUARTER_ON = curr_ff ? cq_ff : v_quarter;
    assign CURR_MODE = curr_ff;

endmodule // svcu_top

// *** hw/svcu_pkg.sv ***
// Shared constants and types of the supply voltage command unit.
package svcu_pkg;
    localparam int unsigned CLK_FREQ_HZ = 10000000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S;
    localparam int unsigned TRAN_MAX_MS = 10000;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [15:0] MODEL_MAX_DEF = 16'hffff;
    localparam logic [15:0] MODEL_MIN_DEF = 16'h0000;
    localparam logic [15:0] QUARTER_DEF = 16'h4000;
    localparam logic [15:0] ERR_RANGE = 16'hff22;
    localparam logic [15:0] ERR_COMMAND = 16'hff9c;
    localparam logic [15:0] RANGE_FULL = 16'h0001;
    localparam logic [15:0] RANGE_QUARTER = 16'h0004;
    localparam int unsigned OPC_CV_BIT = 8;
    localparam int unsigned OPC_CC_BIT = 10;
    localparam logic AUTO_RANGE_RST = 1'b1;

    typedef enum logic [4:0] {
        CMD_VOLT_SET = 5'h00,
        CMD_VOLT_QUERY = 5'h01,
        CMD_MODE_FIX = 5'h02,
        CMD_MODE_LIST = 5'h03,
        CMD_MODE_TRAN = 5'h04,
        CMD_MODE_QUERY = 5'h05,
        CMD_RANGE_SET = 5'h06,
        CMD_RANGE_QUERY = 5'h07,
        CMD_AUTO_SET = 5'h08,
        CMD_TRIG_SET = 5'h09,
        CMD_TRIG_QUERY = 5'h0a,
        CMD_TRIGGER = 5'h0b,
        CMD_OPC_QUERY = 5'h0c,
        CMD_LIST_DEF = 5'h0d,
        CMD_RESET = 5'h0e,
        CMD_FUNC_MODE = 5'h0f,
        CMD_LIMIT_SET = 5'h10
    } svcu_cmd_e;

    typedef enum logic [1:0] {
        QUAL_NONE = 2'b00,
        QUAL_MIN = 2'b01,
        QUAL_MAX = 2'b10
    } svcu_qual_e;

    typedef enum logic [1:0] {
        MODE_FIXED = 2'b00,
        MODE_LIST = 2'b01,
        MODE_ARMED = 2'b10,
        MODE_PULSE = 2'b11
    } svcu_state_e;

    typedef enum logic [1:0] {
        REPLY_FIXED = 2'b00,
        REPLY_LIST = 2'b01,
        REPLY_TRANS = 2'b10
    } svcu_mode_reply_e;
endpackage

// *** sim/svcu_assertions.sv ***
// Port-level checker for the supply voltage command unit.
`timescale 1ns/10ps
module svcu_checker #(
    parameter logic [15:0] MODEL_MAX = 16'hffff
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Command and replies
    input wire logic CMD_VALID,
    input wire logic [4:0] CMD_CODE,
    input wire logic [15:0] CMD_ARG,
    input wire logic RSP_VALID,
    input wire logic [15:0] RSP_DATA,
    input wire logic ERR_VALID,
    input wire logic [15:0] ERR_CODE,
    // Output state
    input wire logic LIST_RUN,
    input wire logic [15:0] OUT_LEVEL,
    input wire logic [15:0] DAC_CODE,
    input wire logic RANGE_QUARTER_ON,
    input wire logic CURR_MODE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire [17:0] quad = {OUT_LEVEL, 2'b00};
    wire [15:0] quad_sat = (|quad[17:16]) ? 16'hffff : quad[15:0];
    wire is_query = CMD_VALID && (CMD_CODE == svcu_pkg::CMD_VOLT_QUERY
        || CMD_CODE == svcu_pkg::CMD_MODE_QUERY || CMD_CODE == svcu_pkg::CMD_RANGE_QUERY
        || CMD_CODE == svcu_pkg::CMD_TRIG_QUERY || CMD_CODE == svcu_pkg::CMD_OPC_QUERY);
    wire is_set = CMD_VALID && (CMD_CODE == svcu_pkg::CMD_VOLT_SET
        || CMD_CODE == svcu_pkg::CMD_TRIG_SET);

    a_err_over_max: assert property (is_set && CMD_ARG > MODEL_MAX |=>
        ERR_VALID && ERR_CODE == svcu_pkg::ERR_RANGE) else $error("range error missing");
    a_level_store: assert property (is_set && CMD_CODE == svcu_pkg::CMD_VOLT_SET
        && CMD_ARG <= MODEL_MAX && !LIST_RUN |=> OUT_LEVEL == $past(CMD_ARG))
        else $error("level not stored");
    a_query_answer: assert property (is_query |=> RSP_VALID && !ERR_VALID)
        else $error("query without reply");
    a_list_reject: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_LIST_DEF
        && LIST_RUN |=> ERR_VALID && ERR_CODE == svcu_pkg::ERR_COMMAND)
        else $error("list definition accepted");
    a_list_abort: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_MODE_FIX
        && LIST_RUN |=> !LIST_RUN) else $error("list not aborted");
    a_mode_list: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_MODE_QUERY
        && LIST_RUN |=> RSP_DATA == 16'h0001) else $error("mode reply not list");
    a_range_reply: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_RANGE_QUERY
        |=> RSP_DATA == ($past(RANGE_QUARTER_ON) ? svcu_pkg::RANGE_QUARTER
        : svcu_pkg::RANGE_FULL)) else $error("range reply wrong");
    a_range_bad: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_RANGE_SET
        && !(CMD_ARG inside {16'h0001, 16'h0004}) |=> ERR_VALID
        && ERR_CODE == svcu_pkg::ERR_RANGE) else $error("bad range accepted");
    a_opc_word: assert property (CMD_VALID && CMD_CODE == svcu_pkg::CMD_OPC_QUERY
        |=> RSP_DATA == {5'h00, $past(CURR_MODE), 1'b0, ~$past(CURR_MODE), 8'h00})
        else $error("condition word wrong");
    a_dac_map: assert property (1'b1 |=> DAC_CODE == ($past(RANGE_QUARTER_ON)
        ? $past(quad_sat) : $past(OUT_LEVEL))) else $error("converter code wrong");

    c_list_done: cover property (LIST_RUN ##1 !LIST_RUN);
    c_cmd_err: cover property (ERR_VALID && ERR_CODE == svcu_pkg::ERR_COMMAND);
    c_quarter: cover property ($rose(RANGE_QUARTER_ON));
endmodule // svcu_checker

// *** sim/svcu_list_seq.sv ***
// Behavioural list sequencer feeding two steps while the list runs.
`timescale 1ns/10ps
module svcu_list_seq #(
    parameter logic [15:0] STEP_A = 16'h2222,
    parameter logic [15:0] STEP_B = 16'h3333
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control from unit and bench
    input wire logic run,
    input wire logic finish,
    // Step stream
    output logic step_valid,
    output logic [15:0] step_level,
    output logic step_end
);
    logic [7:0] cnt;
    initial begin
        step_valid = 1'b0;
        step_end = 1'b0;
        step_level = 16'h0000;
    end
    // The level line flips outside steps so a stale value is never mistaken for data.
    always @(posedge clk) begin
        #1;
        cnt = (rst || !run) ? 8'h00 : cnt + 8'h01;
        step_valid = (cnt == 8'h03 || cnt == 8'h06);
        step_level = (cnt == 8'h03) ? STEP_A : (cnt == 8'h06) ? STEP_B : ~step_level;
        step_end = finish && cnt == 8'h09;
    end
endmodule // svcu_list_seq

// *** sim/svcu_top_test.sv ***
// Self-checking bench for the supply voltage command unit.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module svcu_top_test;
    localparam logic [15:0] MAXV = 16'hf000;
    logic CLK_SYS;
    logic RST;
    logic CMD_VALID;
    logic [4:0] CMD_CODE;
    logic [1:0] CMD_QUAL;
    logic [15:0] CMD_ARG;
    logic finish;
    logic RSP_VALID, ERR_VALID, LIST_RUN, LIST_STEP_VALID, LIST_END, RANGE_QUARTER_ON, CURR_MODE;
    logic [15:0] RSP_DATA, ERR_CODE, LIST_STEP_LEVEL, OUT_LEVEL, DAC_CODE, v;
    logic [16:0] exp_e;
    logic [16:0] expq[$];
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'had91c7af;
    int cnt;

    svcu_top #(.CYC_PER_MS(2), .MODEL_MAX(MAXV)) dut (.CLK_SYS(CLK_SYS), .RST(RST),
        .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_QUAL(CMD_QUAL), .CMD_ARG(CMD_ARG),
        .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE),
        .LIST_RUN(LIST_RUN), .LIST_STEP_VALID(LIST_STEP_VALID),
        .LIST_STEP_LEVEL(LIST_STEP_LEVEL), .LIST_END(LIST_END), .OUT_LEVEL(OUT_LEVEL),
        .DAC_CODE(DAC_CODE), .RANGE_QUARTER_ON(RANGE_QUARTER_ON), .CURR_MODE(CURR_MODE));
    svcu_list_seq seq (.clk(CLK_SYS), .rst(RST), .run(LIST_RUN), .finish(finish),
        .step_valid(LIST_STEP_VALID), .step_level(LIST_STEP_LEVEL), .step_end(LIST_END));

    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    task automatic summarize();
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic [4:0] c, input logic [15:0] a, input logic [1:0] q = 2'h0);
        @(posedge CLK_SYS);
        #1;
        CMD_VALID = 1'b1;
        CMD_CODE = c;
        CMD_QUAL = q;
        CMD_ARG = a;
        @(posedge CLK_SYS);
        #1;
        CMD_VALID = 1'b0;
    endtask
    task automatic ask(input logic [4:0] c, input logic [16:0] e, input logic [1:0] q = 2'h0);
        expq.push_back(e);
        cmd(c, 16'h0000, q);
    endtask
    // Counts the cycles for which the output shows a pulse level.
    task automatic pulse(input logic [15:0] lv);
        cnt = 0;
        repeat (30) begin
            if (OUT_LEVEL === lv) cnt++;
            @(posedge CLK_SYS);
            #2;
        end
    endtask
    // Any reply or error pulse must match the oldest expectation; unexpected pulses fail.
    always @(posedge CLK_SYS) begin
        #2;
        if (RSP_VALID === 1'b1 || ERR_VALID === 1'b1) begin
            exp_e = (expq.size() > 0) ? expq.pop_front() : 17'bx;
            `CHK("reply", exp_e, {ERR_VALID, ERR_VALID ? ERR_CODE : RSP_DATA})
        end
    end
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        RST = 1'b1;
        CMD_VALID = 1'b0;
        CMD_CODE = 5'h00;
        CMD_QUAL = 2'h0;
        CMD_ARG = 16'h0000;
        finish = 1'b0;
        repeat (6) @(posedge CLK_SYS);
        #1;
        RST = 1'b0;
        ask(svcu_pkg::CMD_MODE_QUERY, 17'h00000);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00004);
        ask(svcu_pkg::CMD_VOLT_QUERY, {1'b0, MAXV}, svcu_pkg::QUAL_MAX);
        ask(svcu_pkg::CMD_VOLT_QUERY, 17'h00000, svcu_pkg::QUAL_MIN);
        expq.push_back(17'h1ff22);
        cmd(svcu_pkg::CMD_VOLT_SET, MAXV + 16'h0001);
        ask(svcu_pkg::CMD_VOLT_QUERY, 17'h00000);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h4000);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00004);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h4001);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00001);
        repeat (4) begin
            v = 16'($random(seed)) & 16'h7fff;
            cmd(svcu_pkg::CMD_VOLT_SET, v);
            ask(svcu_pkg::CMD_VOLT_QUERY, {1'b0, v});
            ask(svcu_pkg::CMD_RANGE_QUERY, (v > 16'h4000) ? 17'h00001 : 17'h00004);
        end
        cmd(svcu_pkg::CMD_RANGE_SET, 16'h0004);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h8000);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00004);
        `CHK("dac", 16'hffff, DAC_CODE)
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h1000);
        @(posedge CLK_SYS);
        #2;
        `CHK("dac", 16'h4000, DAC_CODE)
        expq.push_back(17'h1ff22);
        cmd(svcu_pkg::CMD_RANGE_SET, 16'h0002);
        cmd(svcu_pkg::CMD_RESET, 16'h0000);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00004);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h8000);
        cmd(svcu_pkg::CMD_AUTO_SET, 16'h0000);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h1000);
        ask(svcu_pkg::CMD_RANGE_QUERY, 17'h00001);
        cmd(svcu_pkg::CMD_FUNC_MODE, 16'h0001);
        ask(svcu_pkg::CMD_OPC_QUERY, 17'h00400);
        cmd(svcu_pkg::CMD_FUNC_MODE, 16'h0000);
        ask(svcu_pkg::CMD_OPC_QUERY, 17'h00100);
        cmd(svcu_pkg::CMD_LIMIT_SET, 16'h2800);
        cmd(svcu_pkg::CMD_TRIG_SET, 16'h3000);
        ask(svcu_pkg::CMD_TRIG_QUERY, 17'h02800);
        expq.push_back(17'h1ff22);
        cmd(svcu_pkg::CMD_TRIG_SET, MAXV + 16'h0001);
        ask(svcu_pkg::CMD_TRIG_QUERY, 17'h02800);
        cmd(svcu_pkg::CMD_MODE_TRAN, 16'h0002);
        ask(svcu_pkg::CMD_MODE_QUERY, 17'h00002);
        cmd(svcu_pkg::CMD_TRIGGER, 16'h0000);
        pulse(16'h2800);
        `CHK("trig pulse", 4, cnt)
        `CHK("level", 16'h1000, OUT_LEVEL)
        expq.push_back(17'h1ff22);
        cmd(svcu_pkg::CMD_MODE_TRAN, 16'd10001);
        cmd(svcu_pkg::CMD_MODE_TRAN, 16'h0003);
        cmd(svcu_pkg::CMD_VOLT_SET, 16'h2000);
        pulse(16'h2000);
        `CHK("volt pulse", 6, cnt)
        `CHK("level", 16'h1000, OUT_LEVEL)
        ask(svcu_pkg::CMD_MODE_QUERY, 17'h00000);
        cmd(svcu_pkg::CMD_LIST_DEF, 16'h0000);
        cmd(svcu_pkg::CMD_MODE_LIST, 16'h0000);
        ask(svcu_pkg::CMD_MODE_QUERY, 17'h00001);
        repeat (8) @(posedge CLK_SYS);
        expq.push_back(17'h1ff9c);
        cmd(svcu_pkg::CMD_LIST_DEF, 16'h0000);
        cmd(svcu_pkg::CMD_MODE_FIX, 16'h0000);
        ask(svcu_pkg::CMD_VOLT_QUERY, 17'h01000);
        finish = 1'b1;
        cmd(svcu_pkg::CMD_MODE_LIST, 16'h0000);
        for (int i = 0; i < 30 && LIST_RUN !== 1'b0; i++) begin
            @(posedge CLK_SYS);
            #1;
        end
        ask(svcu_pkg::CMD_VOLT_QUERY, 17'h03333);
        ask(svcu_pkg::CMD_MODE_QUERY, 17'h00000);
        repeat (4) @(posedge CLK_SYS);
        `CHK("queue", 0, expq.size())
        summarize();
    end
endmodule // svcu_top_test

bind svcu_top svcu_checker #(.MODEL_MAX(MODEL_MAX)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .ERR_VALID(ERR_VALID), .ERR_CODE(ERR_CODE), .LIST_RUN(LIST_RUN),
    .OUT_LEVEL(OUT_LEVEL), .DAC_CODE(DAC_CODE), .RANGE_QUARTER_ON(RANGE_QUARTER_ON),
    .CURR_MODE(CURR_MODE));
